// ==== core/spi_client_cfg.svh ====
`ifndef SPI_CLIENT_CFG_SVH
`define SPI_CLIENT_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SPI_OFS_CTRLA 3'h0
`define SPI_OFS_CONTROL_B_REGISTER 3'h1
`define SPI_OFS_INTERRUPT_CONTROL_REGISTER 3'h2
`define SPI_OFS_INTERRUPT_FLAG_REGISTER 3'h3
`define SPI_OFS_DATA 3'h4

// ----------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------
`define SPI_CTRLA_MASK 8'h77
`define SPI_CONTROL_B_REGISTER_MASK 8'hc7
`define SPI_INTERRUPT_CONTROL_REGISTER_MASK 8'hf1
`define SPI_CTRL_RESET 8'h00
`define SPI_BYTE_ZERO 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPI_CTRLA_ENABLE 0
`define SPI_CTRLA_DORD 6
`define SPI_CONTROL_B_REGISTER_BUFFER_MODE_ENABLE 7
`define SPI_CONTROL_B_REGISTER_WAIT_RECEIVE_SELECT 6
`define SPI_CONTROL_B_REGISTER_MODE_HI 1
`define SPI_CONTROL_B_REGISTER_MODE_LO 0
`define SPI_INT_RXC 7
`define SPI_INT_TXC 6
`define SPI_INT_DRE 5
`define SPI_INT_SSI 4
`define SPI_INT_OVF 0
`define SPI_INT_IE 0
`define SPI_INT_WRITE_COLLISION_FLAG 6

// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define SPI_LAST_BIT 3'h7
`define SPI_RX_DEPTH 2'h2

`endif

// ==== core/spi_client_pkg.sv ====
`default_nettype none
package spi_client_pkg;
    // client framing state, follows the synchronised select
    typedef enum logic {ST_IDLE, ST_ACTIVE} xfer_state_t;
    typedef logic [7:0] spi_byte_t;
endpackage
`default_nettype wire

// ==== core/spi_client_buffered_select.sv ====
// Implementation choices: strobed register access and the register addresses.
`include "spi_client_cfg.svh"
`default_nettype none
module spi_client_buffered_select (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic miso_dir_out,
    output logic miso_out,
    output logic miso_oe_n,
    output logic sck_event,
    output logic irq
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs, input logic stb);
        hit = stb && (a == ofs);
    endfunction

    function automatic spi_client_pkg::spi_byte_t shift_in(input spi_client_pkg::spi_byte_t b,
                                                           input logic din, input logic lsb_first);
        shift_in = lsb_first ? {din, b[7:1]} : {b[6:0], din};
    endfunction

    function automatic logic out_bit(input spi_client_pkg::spi_byte_t b, input logic lsb_first);
        out_bit = lsb_first ? b[0] : b[7];
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic sck_s1_ff, sck_s2_ff, sck_s3_ff;
    logic ss_s1_ff, ss_s2_ff;
    logic mosi_s1_ff, mosi_s2_ff;
    logic [7:0] ctrla_ff, control_b_register_ff, interrupt_control_register_ff;
    spi_client_pkg::xfer_state_t state_ff, nxt_state;
    logic [2:0] bit_cnt_ff;
    spi_client_pkg::spi_byte_t shreg_ff, txbuf_ff, rx_head_ff, rx_buf_ff, rx_byte;
    logic [1:0] rx_cnt_ff;
    logic dre_ff, shreg_free_ff;
    logic done_d1_ff, done_d2_ff, sent_all_ff;
    logic rxc_flag_ff, txc_flag_ff, ssi_flag_ff, ovf_flag_ff, write_collision_flag_flag_ff;
    logic miso_ff, miso_oe_n_ff, sck_event_ff, irq_ff;
    logic [7:0] rd_data_ff, nxt_rd_data;
    logic enable, dord, buffer_mode_enable, wait_receive_select, sample_on_rise;
    logic selected, rise, fall, sample_go, setup_go, xfer_done;
    logic data_wr, data_rd, flags_wr, early_load, normal_load, busy;
    logic push, pop;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    // select, clock and data each cross through two flops; clock gets a third stage, read with stage two for edge detection
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sck_s1_ff <= 1'b0;
            sck_s2_ff <= 1'b0;
            sck_s3_ff <= 1'b0;
            ss_s1_ff <= 1'b1;
            ss_s2_ff <= 1'b1;
            mosi_s1_ff <= 1'b0;
            mosi_s2_ff <= 1'b0;
        end else begin
            sck_s1_ff <= sck;
            sck_s2_ff <= sck_s1_ff;
            sck_s3_ff <= sck_s2_ff;
            ss_s1_ff <= ss_n;
            ss_s2_ff <= ss_s1_ff;
            mosi_s1_ff <= mosi;
            mosi_s2_ff <= mosi_s1_ff;
        end
    end

    // event output is the synchronised serial clock level, no event input exists
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sck_event_ff <= 1'b0;
        end else begin
            sck_event_ff <= sck_s2_ff;
        end
    end

    // ----------------------------------------------------------------
    // configuration decode
    // ----------------------------------------------------------------
    assign enable = ctrla_ff[`SPI_CTRLA_ENABLE];
    assign dord = ctrla_ff[`SPI_CTRLA_DORD];
    assign buffer_mode_enable = control_b_register_ff[`SPI_CONTROL_B_REGISTER_BUFFER_MODE_ENABLE];
    assign wait_receive_select = control_b_register_ff[`SPI_CONTROL_B_REGISTER_WAIT_RECEIVE_SELECT];
    // modes 0 and 3 sample on the rising edge, 1 and 2 on the falling edge
    assign sample_on_rise = ~(control_b_register_ff[`SPI_CONTROL_B_REGISTER_MODE_HI] ^ control_b_register_ff[`SPI_CONTROL_B_REGISTER_MODE_LO]);
    assign selected = enable && !ss_s2_ff;
    assign rise = sck_s2_ff && !sck_s3_ff;
    assign fall = !sck_s2_ff && sck_s3_ff;
    assign sample_go = selected && (sample_on_rise ? rise : fall);
    assign setup_go = selected && (sample_on_rise ? fall : rise);
    assign xfer_done = sample_go && (bit_cnt_ff == `SPI_LAST_BIT);
    assign rx_byte = shift_in(shreg_ff, mosi_s2_ff, dord);

    // ----------------------------------------------------------------
    // register bus strobes
    // ----------------------------------------------------------------
    assign data_wr = hit(addr, `SPI_OFS_DATA, wr_en);
    assign data_rd = hit(addr, `SPI_OFS_DATA, rd_en);
    assign flags_wr = hit(addr, `SPI_OFS_INTERRUPT_FLAG_REGISTER, wr_en);
    assign busy = (bit_cnt_ff != 3'h0) || sample_go;
    // unbuffered write lands straight in the shift register when idle
    assign normal_load = data_wr && !buffer_mode_enable && !busy;
    // wait-for-receive: first write while deselected skips the buffer one cycle later
    assign early_load = buffer_mode_enable && wait_receive_select && !selected && shreg_free_ff && !dre_ff;
    assign push = xfer_done && buffer_mode_enable;
    assign pop = data_rd && buffer_mode_enable && (rx_cnt_ff != 2'h0);

    // control registers, reserved bits held at zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrla_ff <= `SPI_CTRL_RESET;
            control_b_register_ff <= `SPI_CTRL_RESET;
            interrupt_control_register_ff <= `SPI_CTRL_RESET;
        end else begin
            if (hit(addr, `SPI_OFS_CTRLA, wr_en)) begin
                ctrla_ff <= wr_data & `SPI_CTRLA_MASK;
            end
            if (hit(addr, `SPI_OFS_CONTROL_B_REGISTER, wr_en)) begin
                control_b_register_ff <= wr_data & `SPI_CONTROL_B_REGISTER_MASK;
            end
            if (hit(addr, `SPI_OFS_INTERRUPT_CONTROL_REGISTER, wr_en)) begin
                interrupt_control_register_ff <= wr_data & `SPI_INTERRUPT_CONTROL_REGISTER_MASK;
            end
        end
    end

    // ----------------------------------------------------------------
    // framing state and bit counter
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            spi_client_pkg::ST_IDLE: begin
                if (selected) begin
                    nxt_state = spi_client_pkg::ST_ACTIVE;
                end
            end
            spi_client_pkg::ST_ACTIVE: begin
                if (!selected) begin
                    nxt_state = spi_client_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_ff <= spi_client_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // deselect clears the count at once so the next byte starts aligned
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bit_cnt_ff <= 3'h0;
        end else if (!selected) begin
            bit_cnt_ff <= 3'h0;
        end else if (sample_go) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // shift register and transmit buffer
    // ----------------------------------------------------------------
    // the shift register is full duplex; left untouched it is the dummy byte
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            shreg_ff <= `SPI_BYTE_ZERO;
        end else if (push && !dre_ff) begin
            shreg_ff <= txbuf_ff;
        end else if (sample_go) begin
            shreg_ff <= rx_byte;
        end else if (early_load) begin
            shreg_ff <= txbuf_ff;
        end else if (normal_load) begin
            shreg_ff <= wr_data;
        end
    end

    // every buffered write goes to the buffer; a write while full is lost
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txbuf_ff <= `SPI_BYTE_ZERO;
            dre_ff <= 1'b1;
        end else if (data_wr && buffer_mode_enable && dre_ff) begin
            txbuf_ff <= wr_data;
            dre_ff <= 1'b0;
        end else if ((push || early_load) && !dre_ff) begin
            dre_ff <= 1'b1;
        end
    end

    // tracks whether the shift register may take a write while deselected
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            shreg_free_ff <= 1'b1;
        end else if (early_load) begin
            shreg_free_ff <= 1'b0;
        end else if (push) begin
            shreg_free_ff <= dre_ff;
        end
    end

    // miso follows the next outgoing bit between bytes, else moves on setup edges
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            miso_ff <= 1'b0;
            miso_oe_n_ff <= 1'b1;
        end else begin
            if ((bit_cnt_ff == 3'h0) || setup_go) begin
                miso_ff <= out_bit(shreg_ff, dord);
            end
            miso_oe_n_ff <= !(selected && miso_dir_out);
        end
    end

    // ----------------------------------------------------------------
    // receive queue
    // ----------------------------------------------------------------
    // two entries; unbuffered mode uses the head only and overwrites it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_head_ff <= `SPI_BYTE_ZERO;
            rx_buf_ff <= `SPI_BYTE_ZERO;
            rx_cnt_ff <= 2'h0;
        end else if (xfer_done && !buffer_mode_enable) begin
            rx_head_ff <= rx_byte;
        end else if (push && pop) begin
            if (rx_cnt_ff == 2'h1) begin
                rx_head_ff <= rx_byte;
            end else begin
                rx_head_ff <= rx_buf_ff;
                rx_buf_ff <= rx_byte;
            end
        end else if (push) begin
            if (rx_cnt_ff == 2'h0) begin
                rx_head_ff <= rx_byte;
                rx_cnt_ff <= 2'h1;
            end else if (rx_cnt_ff == 2'h1) begin
                rx_buf_ff <= rx_byte;
                rx_cnt_ff <= `SPI_RX_DEPTH;
            end
        end else if (pop) begin
            rx_head_ff <= rx_buf_ff;
            rx_cnt_ff <= rx_cnt_ff - 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // flags
    // ----------------------------------------------------------------
    // delay line spacing buffer-empty, receive and transfer flags one cycle apart
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            done_d1_ff <= 1'b0;
            done_d2_ff <= 1'b0;
            sent_all_ff <= 1'b0;
        end else begin
            done_d1_ff <= push;
            done_d2_ff <= done_d1_ff;
            if (push) begin
                sent_all_ff <= dre_ff;
            end
        end
    end

    // set beats a clear arriving in the same cycle, for every flag
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rxc_flag_ff <= 1'b0;
        end else if (buffer_mode_enable ? done_d1_ff : xfer_done) begin
            rxc_flag_ff <= 1'b1;
        end else if (flags_wr && wr_data[`SPI_INT_RXC]) begin
            rxc_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txc_flag_ff <= 1'b0;
        end else if (done_d2_ff && sent_all_ff) begin
            txc_flag_ff <= 1'b1;
        end else if (flags_wr && wr_data[`SPI_INT_TXC]) begin
            txc_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ssi_flag_ff <= 1'b0;
        end else if (buffer_mode_enable && selected && (state_ff == spi_client_pkg::ST_IDLE)) begin
            ssi_flag_ff <= 1'b1;
        end else if (flags_wr && wr_data[`SPI_INT_SSI]) begin
            ssi_flag_ff <= 1'b0;
        end
    end

    // a byte arriving with both queue entries full is dropped and flagged
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ovf_flag_ff <= 1'b0;
        end else if (push && !pop && (rx_cnt_ff == `SPI_RX_DEPTH)) begin
            ovf_flag_ff <= 1'b1;
        end else if (flags_wr && wr_data[`SPI_INT_OVF]) begin
            ovf_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            write_collision_flag_flag_ff <= 1'b0;
        end else if (data_wr && !buffer_mode_enable && busy) begin
            write_collision_flag_flag_ff <= 1'b1;
        end else if (flags_wr && wr_data[`SPI_INT_WRITE_COLLISION_FLAG]) begin
            write_collision_flag_flag_ff <= 1'b0;
        end
    end

    // single request line; sources depend on buffer mode
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else if (buffer_mode_enable) begin
            irq_ff <= (rxc_flag_ff && interrupt_control_register_ff[`SPI_INT_RXC]) || (txc_flag_ff && interrupt_control_register_ff[`SPI_INT_TXC])
                   || (dre_ff && interrupt_control_register_ff[`SPI_INT_DRE]) || (ssi_flag_ff && interrupt_control_register_ff[`SPI_INT_SSI]);
        end else begin
            irq_ff <= interrupt_control_register_ff[`SPI_INT_IE] && (rxc_flag_ff || write_collision_flag_flag_ff);
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        nxt_rd_data = `SPI_BYTE_ZERO;
        if (rd_en) begin
            if (addr == `SPI_OFS_CTRLA) begin
                nxt_rd_data = ctrla_ff;
            end else if (addr == `SPI_OFS_CONTROL_B_REGISTER) begin
                nxt_rd_data = control_b_register_ff;
            end else if (addr == `SPI_OFS_INTERRUPT_CONTROL_REGISTER) begin
                nxt_rd_data = interrupt_control_register_ff;
            end else if (addr == `SPI_OFS_INTERRUPT_FLAG_REGISTER) begin
                nxt_rd_data = buffer_mode_enable ? {rxc_flag_ff, txc_flag_ff, dre_ff, ssi_flag_ff, 3'h0, ovf_flag_ff}
                                    : {rxc_flag_ff, write_collision_flag_flag_ff, 6'h00};
            end else if (addr == `SPI_OFS_DATA) begin
                nxt_rd_data = rx_head_ff;
            end
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_data_ff <= `SPI_BYTE_ZERO;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data = rd_data_ff;
    assign miso_out = miso_ff;
    assign miso_oe_n = miso_oe_n_ff;
    assign sck_event = sck_event_ff;
    assign irq = irq_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_copy_at_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        push && !dre_ff |=> dre_ff && (shreg_ff == $past(txbuf_ff)))
        else $error("buffer byte not moved to shift register at transfer end");

    a_full_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        data_wr && buffer_mode_enable && !dre_ff |=> txbuf_ff == $past(txbuf_ff))
        else $error("write into full buffer was not dropped");

    a_rxc_after_dre: assert property (@(posedge sys_clk) disable iff (!rst_n)
        push |-> ##1 dre_ff ##1 rxc_flag_ff)
        else $error("receive-complete not one cycle after buffer-empty");

    a_txc_all_sent: assert property (@(posedge sys_clk) disable iff (!rst_n)
        push && dre_ff |-> ##3 txc_flag_ff)
        else $error("transfer-complete missing after full drain");

    a_txc_pending: assert property (@(posedge sys_clk) disable iff (!rst_n)
        push && !dre_ff && !txc_flag_ff ##1 !done_d2_ff[*2] |-> !txc_flag_ff)
        else $error("transfer-complete set while a byte was still pending");

    a_early_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (data_wr && buffer_mode_enable && wait_receive_select && dre_ff && shreg_free_ff && !selected && !xfer_done) ##1 !selected
        |=> shreg_ff == $past(wr_data, 2))
        else $error("write while deselected did not reach shift register");

    a_deselect_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ss_s2_ff |=> bit_cnt_ff == 3'h0 && state_ff == spi_client_pkg::ST_IDLE)
        else $error("deselect did not reset the bit counter");

    a_miso_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(ss_s2_ff) |=> miso_oe_n ##1 miso_oe_n)
        else $error("miso driven while deselected");

    a_event_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(sck_s2_ff) |=> sck_event == $past(sck_s2_ff))
        else $error("clock event does not follow synchronised sck");

    a_write_collision_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        data_wr && !buffer_mode_enable && bit_cnt_ff != 3'h0 |=> write_collision_flag_flag_ff && shreg_ff != $past(wr_data) || $past(sample_go))
        else $error("write collision not flagged");

    a_irq_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        buffer_mode_enable && rxc_flag_ff && interrupt_control_register_ff[`SPI_INT_RXC] && $stable(control_b_register_ff) |=> irq)
        else $error("interrupt request not raised for enabled flag");

endmodule
`default_nettype wire

// ==== bench/spi_host_model.sv ====
`default_nettype none
// ----------------------------------------------------------------
// host side of the serial link
// ----------------------------------------------------------------
module spi_host_model (
    output var logic sck,
    output var logic ss_n,
    output var logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ns;
    // link stands still and deselected until a frame is opened
    initial begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end
    // idle level follows polarity; the 13 ns skew keeps edges off the system clock edge
    task automatic sel(input logic [1:0] mode, input logic on);
        #13;
        sck = mode[1];
        #320;
        ss_n = ~on;
        #320;
    endtask
    // 160 ns phases keep each level well over two system clocks
    task automatic xfer(input logic [1:0] mode, input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            if (!mode[0]) begin
                mosi = tx[i];
                #160;
                rx[i] = miso;
                sck = ~sck;
                #160;
                sck = ~sck;
            end else begin
                sck = ~sck;
                mosi = tx[i];
                #160;
                rx[i] = miso;
                sck = ~sck;
                #160;
            end
        end
    endtask
endmodule
`default_nettype wire

// ==== bench/test_spi_client_buffered_select.sv ====
`default_nettype none
module test_spi_client_buffered_select;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, miso_dir_out = 1'b1, last_ff = 1'b0;
    logic irq_exp = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wr_data = 8'h00, rd_data, got, a, b, c, prev = 8'h00, d;
    logic sck, ss_n, mosi, miso_out, miso_oe_n, sck_event, irq, miso_line;
    int error_cnt = 0, num_checks = 0;
    // ----------------------------------------------------------------
    // clock, design and partner
    // ----------------------------------------------------------------
    always #20 sys_clk = ~sys_clk;
    spi_client_buffered_select uut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sck(sck), .ss_n(ss_n), .mosi(mosi),
        .miso_dir_out(miso_dir_out), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .sck_event(sck_event), .irq(irq));
    spi_host_model host (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso_line));
    // a released line shows the inverse of its last level so stale data never passes
    always_ff @(posedge sys_clk) if (!miso_oe_n) last_ff <= miso_out;
    assign miso_line = miso_oe_n ? ~last_ff : miso_out;
    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a_in, input logic [7:0] d_in);
        @(posedge sys_clk);
        addr <= a_in;
        wr_data <= d_in;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [2:0] a_in, input logic [7:0] exp, input string what);
        @(posedge sys_clk);
        addr <= a_in;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        chk(what, exp, rd_data);
    endtask
    // one byte each way, then flags, irq, and the byte the client received
    task automatic xfer_chk(input logic [1:0] m, input logic [7:0] exp_out, input logic out_known,
        input logic [7:0] tx, input logic [7:0] exp_flags);
        logic [7:0] rx;
        host.xfer(m, tx, 8, rx);
        if (out_known) chk("miso byte", exp_out, rx);
        repeat (8) @(posedge sys_clk);
        rd_chk(3'h3, exp_flags, "flags");
        chk("irq set", {7'h00, irq_exp}, {7'h00, irq});
        wr(3'h3, 8'hff);
        rd_chk(3'h4, tx, "rx data");
        chk("irq clear", 8'h00, {7'h00, irq});
    endtask
    // expected value for an lsb-first client seen by an msb-first host
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int k = 0; k < 8; k++) rev[k] = v[7 - k];
    endfunction
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // watchdog well beyond the expected run of some 80 us
    initial begin
        #2_000_000;
        error_cnt++;
        conclude;
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hd6e376bd));
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int r = 0; r < 3; r++) rd_chk(r[2:0], 8'h00, "ctrl reset");
        rd_chk(3'h3, 8'h00, "flags reset");
        wr(3'h5, 8'hff);
        rd_chk(3'h5, 8'h00, "unmapped");
        chk("oe idle", 8'h01, {7'h00, miso_oe_n});
        wr(3'h0, 8'h01);
        // every mode in both wait settings; bytes a, b, c written while deselected
        for (int i = 0; i < 8; i++) begin
            a = $urandom;
            b = $urandom;
            c = $urandom;
            host.sel(i[1:0], 1'b0);
            wr(3'h1, {1'b1, i[2], 4'h0, i[1:0]});
            wr(3'h3, 8'hff);
            wr(3'h4, a);
            rd_chk(3'h3, i[2] ? 8'h20 : 8'h00, "flags after write");
            wr(3'h4, b);
            wr(3'h4, c);
            host.sel(i[1:0], 1'b1);
            wr(3'h3, 8'hff);
            chk("oe selected", 8'h00, {7'h00, miso_oe_n});
            d = $urandom;
            xfer_chk(i[1:0], i[2] ? a : prev, 1'b1, d, 8'ha0);
            prev = $urandom;
            xfer_chk(i[1:0], i[2] ? b : a, 1'b1, prev, 8'he0);
        end
        // abort half a byte, then a clean byte must still line up
        host.sel(2'h3, 1'b0);
        chk("oe deselected", 8'h01, {7'h00, miso_oe_n});
        chk("sck event", {7'h00, sck}, {7'h00, sck_event});
        host.sel(2'h3, 1'b1);
        @(posedge sys_clk) miso_dir_out <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("oe input dir", 8'h01, {7'h00, miso_oe_n});
        @(posedge sys_clk) miso_dir_out <= 1'b1;
        wr(3'h3, 8'hff);
        host.xfer(2'h3, 8'h5a, 4, d);
        host.sel(2'h3, 1'b0);
        repeat (8) @(posedge sys_clk);
        rd_chk(3'h3, 8'h20, "flags after abort");
        host.sel(2'h3, 1'b1);
        wr(3'h3, 8'hff);
        wr(3'h2, 8'h80);
        irq_exp = 1'b1;
        xfer_chk(2'h3, 8'h00, 1'b0, 8'h3c, 8'he0);
        // unbuffered, lsb first: bytes leave and arrive bit reversed for the msb-first host
        irq_exp = 1'b0;
        host.sel(2'h0, 1'b0);
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h41);
        wr(3'h3, 8'hff);
        d = $urandom;
        wr(3'h4, d);
        host.sel(2'h0, 1'b1);
        host.xfer(2'h0, 8'h69, 8, got);
        chk("miso lsb first", rev(d), got);
        repeat (8) @(posedge sys_clk);
        rd_chk(3'h3, 8'h80, "flags unbuffered");
        rd_chk(3'h4, rev(8'h69), "rx lsb first");
        chk("irq unbuffered", 8'h00, {7'h00, irq});
        conclude;
    end
endmodule
`default_nettype wire
